// ==== rtl/sadd_datapath.v ====
// Exchange register, operand register and subtractive adder front end.
`include "sadd_map.vh"

module sadd_datapath #(
	parameter W = `SADD_WIDTH,
	parameter G = `SADD_GROUP
) (
	// Clock and master clear.
	input  wire         clk,
	input  wire         reset_n,

	// Instruction context from control.
	input  wire [5:0]   opcode,
	input  wire [1:0]   seq_kind,
	input  wire [W-1:0] instr_word,
	input  wire [W-1:0] jump_addr,

	// Exchange register step enables.
	input  wire         x_clear,
	input  wire         x_load,
	input  wire [2:0]   x_src,
	input  wire         x_acc_msb,

	// Operand register step enables.
	input  wire         d_clear,
	input  wire         d_load,
	input  wire [3:0]   d_src,

	// Memory side.
	input  wire [W-1:0] mem_rd_data,
	input  wire         mem_wr_take,
	output reg  [W-1:0] mem_wr_data,
	output reg          mem_wr_from_adder,

	// Registers that feed the datapath.
	input  wire [W-1:0] acc,
	input  wire [W-1:0] shift_data,
	input  wire [W-1:0] pc,
	input  wire [W-1:0] index_base,

	// Register contents.
	output wire [W-1:0] x_out,
	output wire [W-1:0] d_out,

	// Adder results.
	output wire [W-1:0] half_sub,
	output wire [W-1:0] half_level,
	output wire [W-1:0] full_sub,
	output wire [W-1:0] borrow_level,
	output wire [W/G-1:0] group_bypass,
	output wire         end_around,

	// Load refused because the source is not legal for the instruction.
	output reg          load_refused
);
	reg  [W-1:0] x_reg;
	reg  [W-1:0] x_next;
	reg  [W-1:0] d_reg;
	reg  [W-1:0] d_next;
	reg  [W-1:0] x_src_word;
	reg  [W-1:0] d_src_word;
	reg          x_ok;
	reg          d_ok;
	reg  [W-1:0] wr_next;
	reg          wr_adder_next;
	reg          refused_next;

	localparam [W-1:0] ONE_WORD = 24'h000001;
	localparam [W-1:0] TWO_WORD = 24'h000002;

	// Accumulator may be copied into the exchange register here only.
	function acc_copy_ok;
		input [5:0] op;
		input [1:0] kind;
		begin
			case (kind)
				`SADD_SEQ_R: begin
					acc_copy_ok = (op == `SADD_OP_EXCHANGE) ||
						(op == `SADD_OP_CLR_LOAD) ||
						(op == `SADD_OP_ADD) ||
						(op == `SADD_OP_SUB) ||
						(op == `SADD_OP_LSUM) ||
						(op == `SADD_OP_LPROD) ||
						(op == `SADD_OP_STORE) ||
						(op == `SADD_OP_REPLACE);
				end
				`SADD_SEQ_I: begin
					acc_copy_ok = (op == `SADD_OP_IDX_ACC) ||
						(op == `SADD_OP_STORE) ||
						(op == `SADD_OP_REPLACE);
				end
				`SADD_SEQ_CHAN: begin
					acc_copy_ok = (op == `SADD_OP_CHANNEL);
				end
				`SADD_SEQ_RELOAD: begin
					acc_copy_ok = (op == `SADD_OP_CHANNEL);
				end
				default: begin
					acc_copy_ok = 1'b0;
				end
			endcase
		end
	endfunction

	// Operations whose operand is the complemented accumulator.
	function acc_cmp_op;
		input [5:0] op;
		begin
			acc_cmp_op = (op == `SADD_OP_NEGATE) ||
				(op == `SADD_OP_COMPARE) ||
				(op == `SADD_OP_LPROD);
		end
	endfunction

	// Instructions that write back data the adder has not touched.
	function unmodified_op;
		input [5:0] op;
		begin
			unmodified_op = (op == `SADD_OP_STORE) ||
				(op == `SADD_OP_REPLACE) ||
				(op == `SADD_OP_EXCHANGE);
		end
	endfunction

	// Logical results are taken without borrows.
	function logical_op;
		input [5:0] op;
		begin
			logical_op = (op == `SADD_OP_LSUM) || (op == `SADD_OP_LPROD);
		end
	endfunction

	// Low address field of a word, upper bits cleared.
	function [W-1:0] addr_field;
		input [W-1:0] w;
		begin
			addr_field = w & {{(W - `SADD_ADDR_BITS){1'b0}},
				{`SADD_ADDR_BITS{1'b1}}};
		end
	endfunction

	// Exchange register source selection and legality.
	always @* begin
		x_src_word = {W{1'b0}};
		x_ok = 1'b1;
		case (x_src)
			`SADD_XS_MEM: begin
				x_src_word = mem_rd_data;
			end
			`SADD_XS_PC: begin
				x_src_word = pc;
			end
			`SADD_XS_INDEX: begin
				x_src_word = index_base;
			end
			`SADD_XS_ACC: begin
				x_ok = acc_copy_ok(opcode, seq_kind);
				if (opcode == `SADD_OP_REPLACE) begin
					x_src_word = addr_field(acc);
				end else begin
					x_src_word = acc;
				end
			end
			`SADD_XS_SHIFT: begin
				// The msb of the accumulator rides into bit zero when asked.
				x_src_word = {shift_data[W-1:1],
					x_acc_msb ? acc[W-1] : shift_data[0]};
			end
			default: begin
				x_ok = 1'b0;
			end
		endcase
	end

	// Operand register source selection and legality.
	always @* begin
		d_src_word = {W{1'b0}};
		d_ok = 1'b1;
		case (d_src)
			`SADD_DS_XFER: begin
				if (opcode == `SADD_OP_SUB) begin
					d_src_word = ~x_reg;
				end else begin
					d_src_word = x_reg;
				end
			end
			`SADD_DS_ACC_CMP: begin
				d_ok = acc_cmp_op(opcode);
				d_src_word = ~acc;
			end
			`SADD_DS_IMM: begin
				d_ok = (opcode == `SADD_OP_ADD_IMM);
				d_src_word = {{(W - 5){1'b0}},
					instr_word[`SADD_IMM_MSB:`SADD_IMM_LSB]};
			end
			`SADD_DS_INDEX: begin
				d_ok = (opcode == `SADD_OP_IDX_ACC);
				d_src_word = index_base;
			end
			`SADD_DS_PLUS1: begin
				d_src_word = ONE_WORD;
			end
			`SADD_DS_PLUS2: begin
				d_src_word = TWO_WORD;
			end
			`SADD_DS_COUNT: begin
				d_src_word = {{(W - `SADD_COUNT_LSB){1'b1}},
					{`SADD_COUNT_LSB{1'b0}}};
			end
			`SADD_DS_JUMP: begin
				d_src_word = jump_addr;
			end
			default: begin
				d_ok = 1'b0;
			end
		endcase
	end

	// Clear acts first, then the load gates into the cleared register, so
	// both enables in one step give a clean copy of the source.
	always @* begin
		x_next = x_clear ? {W{1'b0}} : x_reg;
		if (x_load && x_ok) begin
			x_next = x_next | x_src_word;
		end
		d_next = d_clear ? {W{1'b0}} : d_reg;
		if (d_load && d_ok) begin
			d_next = d_next | d_src_word;
		end
		refused_next = (x_load && !x_ok) || (d_load && !d_ok);
	end

	// Write-back selection toward memory.
	always @* begin
		wr_next = mem_wr_data;
		wr_adder_next = mem_wr_from_adder;
		if (mem_wr_take) begin
			if (unmodified_op(opcode)) begin
				wr_next = x_reg;
				wr_adder_next = 1'b0;
			end else if (logical_op(opcode)) begin
				// Logical results ignore every borrow the adder raises.
				wr_next = half_sub;
				wr_adder_next = 1'b1;
			end else begin
				wr_next = full_sub;
				wr_adder_next = 1'b1;
			end
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			x_reg <= `SADD_RESET_WORD;
			d_reg <= `SADD_RESET_WORD;
			mem_wr_data <= `SADD_RESET_WORD;
			mem_wr_from_adder <= 1'b0;
			load_refused <= 1'b0;
		end else begin
			x_reg <= x_next;
			d_reg <= d_next;
			mem_wr_data <= wr_next;
			mem_wr_from_adder <= wr_adder_next;
			load_refused <= refused_next;
		end
	end

	assign x_out = x_reg;
	assign d_out = d_reg;

	// The adder sees the registers directly; its result follows them at once.
	sadd_adder #(
		.W(W),
		.G(G)
	) u_adder (
		.x           (x_reg),
		.d           (d_reg),
		.half_sub    (half_sub),
		.half_level  (half_level),
		.full_sub    (full_sub),
		.borrow_level(borrow_level),
		.bypass_en   (group_bypass),
		.end_around  (end_around)
	);
endmodule

// ==== rtl/sadd_map.vh ====
// Constants for the subtractive adder datapath: widths, opcodes, source selects.
// How it works
// - Memory words enter only through exchange register.
// - Operated data from adder, unmodified from exchange.
// - Exchange register takes program counter, index base.
// - Store takes full accumulator, replace takes 14.
// - Accumulator copied in listed sequences only.
// - Shift data loads; accumulator msb into lsb.
// - Operand takes exchange straight or complemented.
// - Negate, compare, product: complemented accumulator.
// - Immediate bits 14-18 only for add-immediate.
// - Index-plus-accumulator loads operand from index base.
// - Operand forced to plus one or two.
// - Count decrement sets operand bits 14-23.
// - Operand holds jump destination on transfers.
// - Adder ungated, combinational, always running.
// - Half result ignores borrows; full satisfies all.
// - 24 stages in groups of six.
// - Half bit one when bits differ, low-active.
// - Odd stage borrow request is active zero.
// - Even stage borrow request is active one.
// - Half-bit-one stage absorbs; others pass borrow upward.
// - Unabsorbed top borrow wraps to bottom stage.
// - Passed-through stage complements its half bit.
// - Difference is half bit xor incoming borrow.
// - Equal-bit group raises bypass enable; only all-zero group skips borrow.
`ifndef SADD_MAP_VH
`define SADD_MAP_VH

`define SADD_WIDTH        24
`define SADD_GROUP        6
`define SADD_ADDR_BITS    14
`define SADD_COUNT_LSB    14
`define SADD_IMM_LSB      14
`define SADD_IMM_MSB      18

// Opcodes.
`define SADD_OP_NEGATE    6'h01
`define SADD_OP_CHANNEL   6'h06
`define SADD_OP_STORE     6'h0A
`define SADD_OP_REPLACE   6'h0B
`define SADD_OP_EXCHANGE  6'h10
`define SADD_OP_CLR_LOAD  6'h18
`define SADD_OP_ADD       6'h19
`define SADD_OP_SUB       6'h1A
`define SADD_OP_COMPARE   6'h1B
`define SADD_OP_LSUM      6'h1C
`define SADD_OP_LPROD     6'h1D
`define SADD_OP_IDX_ACC   6'h1E
`define SADD_OP_ADD_IMM   6'h27

// Sequence kinds.
`define SADD_SEQ_I        2'h0
`define SADD_SEQ_R        2'h1
`define SADD_SEQ_CHAN     2'h2
`define SADD_SEQ_RELOAD   2'h3

// Exchange register sources.
`define SADD_XS_MEM       3'h1
`define SADD_XS_PC        3'h2
`define SADD_XS_INDEX     3'h3
`define SADD_XS_ACC       3'h4
`define SADD_XS_SHIFT     3'h5

// Operand register sources.
`define SADD_DS_XFER      4'h1
`define SADD_DS_ACC_CMP   4'h2
`define SADD_DS_IMM       4'h3
`define SADD_DS_INDEX     4'h4
`define SADD_DS_PLUS1     4'h5
`define SADD_DS_PLUS2     4'h6
`define SADD_DS_COUNT     4'h7
`define SADD_DS_JUMP      4'h8

`define SADD_RESET_WORD   24'h000000
`endif

// ==== rtl/sadd_group.v ====
// Six-stage slice of the subtractive adder with its group bypass.
module sadd_group #(
	parameter G = 6
) (
	// Stage inputs.
	input  wire [G-1:0] h,
	input  wire [G-1:0] dbar,
	input  wire         cin,
	// Stage outputs.
	output reg  [G-1:0] full,
	output reg  [G-1:0] req_level,
	output wire         cout,
	output wire         bypass_en
);
	integer i;
	reg     b;
	reg     r;
	reg     chain_out;

	always @* begin
		b = cin;
		r = 1'b0;
		for (i = 0; i < G; i = i + 1) begin
			full[i] = h[i] ^ b;
			// A borrowing stage absorbs from below and asks above itself.
			r = (h[i] & dbar[i]) | (~h[i] & b);
			req_level[i] = i[0] ? ~r : r;
			b = r;
		end
		chain_out = b;
	end

	// Equal half bits mark a group that cannot settle a borrow by itself.
	assign bypass_en = (&h) | (~|h);
	// Only an all-zero group is skipped, which leaves the result unchanged.
	assign cout = (~|h) ? cin : chain_out;
endmodule

// ==== rtl/sadd_adder.v ====
// Ungated 24-bit subtractive adder with end-around borrow.
module sadd_adder #(
	parameter W = 24,
	parameter G = 6
) (
	// Operands straight from the registers.
	input  wire [W-1:0]   x,
	input  wire [W-1:0]   d,
	// Results.
	output wire [W-1:0]   half_sub,
	output wire [W-1:0]   half_level,
	output wire [W-1:0]   full_sub,
	output wire [W-1:0]   borrow_level,
	output wire [W/G-1:0] bypass_en,
	output wire           end_around
);
	wire [W-1:0]   dbar;
	wire [W/G:0]   gcin;

	// Borrow leaving the top stage when nothing enters the bottom.
	function top_borrow;
		input [W-1:0] hh;
		input [W-1:0] dd;
		integer k;
		reg     bb;
		begin
			bb = 1'b0;
			for (k = 0; k < W; k = k + 1)
				bb = (hh[k] & dd[k]) | (~hh[k] & bb);
			top_borrow = bb;
		end
	endfunction

	assign dbar = ~d;
	assign half_sub = x ^ dbar;
	assign half_level = ~half_sub;
	// A second pass with the wrapped borrow settles every stage without a loop.
	assign end_around = top_borrow(half_sub, dbar);
	assign gcin[0] = end_around;

	genvar g;
	generate
		for (g = 0; g < W / G; g = g + 1) begin : grp
			sadd_group #(.G(G)) u_group (
				.h        (half_sub[g*G +: G]),
				.dbar     (dbar[g*G +: G]),
				.cin      (gcin[g]),
				.full     (full_sub[g*G +: G]),
				.req_level(borrow_level[g*G +: G]),
				.cout     (gcin[g+1]),
				.bypass_en(bypass_en[g])
			);
		end
	endgenerate
endmodule

// ==== tb/sadd_sva.sv ====
// Port-level assertions for the subtractive adder datapath.
`include "sadd_map.vh"

module sadd_sva #(
	parameter W = `SADD_WIDTH
) (
	// Clock and controls.
	input wire		clk,
	input wire		reset_n,
	input wire [5:0]	opcode,
	input wire [1:0]	seq_kind,
	input wire		x_clear,
	input wire		x_load,
	input wire [2:0]	x_src,
	input wire		x_acc_msb,
	input wire		d_clear,
	input wire		d_load,
	input wire [3:0]	d_src,
	input wire		mem_wr_take,
	// Data sources.
	input wire [W-1:0]	mem_rd_data,
	input wire [W-1:0]	acc,
	input wire [W-1:0]	shift_data,
	// Results.
	input wire [W-1:0]	x_out,
	input wire [W-1:0]	d_out,
	input wire [W-1:0]	half_sub,
	input wire [W-1:0]	half_level,
	input wire [W-1:0]	full_sub,
	input wire [W/6-1:0]	group_bypass,
	input wire		end_around,
	input wire [W-1:0]	mem_wr_data,
	input wire		mem_wr_from_adder,
	input wire		load_refused
);
	timeunit 1ns;
	timeprecision 1ps;
	// An all-ones sum is the point where the end-around borrow stops wrapping.
	wire [W:0]	sum_w = {1'b0, x_out} + {1'b0, d_out};
	wire [W-1:0]	full_w = (&sum_w[W-1:0]) ? {W{1'b0}} : sum_w[W-1:0] + sum_w[W];

	function automatic [3:0] grp_eq(input [W-1:0] h);
		integer k;
		for (k = 0; k < 4; k = k + 1) grp_eq[k] = (&h[k*6+:6]) | ~(|h[k*6+:6]);
	endfunction

	sequence x_take(logic [2:0] s);
		x_clear && x_load && x_src == s;
	endsequence
	sequence d_take(logic [3:0] s);
		d_clear && d_load && d_src == s;
	endsequence

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	half_out_a: assert property (half_sub == (x_out ^ ~d_out) && half_level == ~half_sub)
		else $error("half result wrong");
	full_out_a: assert property (full_sub == full_w)
		else $error("full result wrong");
	wrap_a: assert property (end_around == (sum_w < {1'b0, {W{1'b1}}}))
		else $error("end around flag wrong");
	bypass_a: assert property (group_bypass == grp_eq(half_sub))
		else $error("group bypass wrong");
	mem_path_a: assert property (x_take(`SADD_XS_MEM) |=> x_out == $past(mem_rd_data))
		else $error("memory word not loaded");
	replace_low_a: assert property (x_take(`SADD_XS_ACC) ##0 (opcode == `SADD_OP_REPLACE
		&& !seq_kind[1]) |=> x_out == {{(W-14){1'b0}}, $past(acc[13:0])})
		else $error("replace load wrong");
	shift_msb_a: assert property (x_take(`SADD_XS_SHIFT) ##0 x_acc_msb
		|=> x_out == {$past(shift_data[W-1:1]), $past(acc[W-1])})
		else $error("shift load wrong");
	sub_cmp_a: assert property (d_take(`SADD_DS_XFER) |=> d_out ==
		(($past(opcode) == `SADD_OP_SUB) ? ~$past(x_out) : $past(x_out)))
		else $error("operand transfer wrong");
	count_ones_a: assert property (d_take(`SADD_DS_COUNT) |=> d_out == {{(W-14){1'b1}}, 14'h0000})
		else $error("count decrement pattern wrong");
	store_back_a: assert property (mem_wr_take && opcode inside {`SADD_OP_STORE,
		`SADD_OP_REPLACE, `SADD_OP_EXCHANGE} |=> mem_wr_data == $past(x_out) && !mem_wr_from_adder)
		else $error("unmodified write-back wrong");
	refuse_a: assert property (x_load && x_src == `SADD_XS_ACC && opcode == `SADD_OP_NEGATE
		|=> load_refused)
		else $error("illegal copy not refused");
endmodule

bind sadd_datapath sadd_sva #(.W(W)) u_sva (.clk, .reset_n, .opcode, .seq_kind, .x_clear,
	.x_load, .x_src, .x_acc_msb, .d_clear, .d_load, .d_src, .mem_wr_take, .mem_rd_data, .acc,
	.shift_data, .x_out, .d_out, .half_sub, .half_level, .full_sub, .group_bypass, .end_around,
	.mem_wr_data, .mem_wr_from_adder, .load_refused);

// ==== tb/sadd_mem_model.sv ====
// Main memory model: combinational read, write one edge after the take pulse.
module sadd_mem_model (
	// Clock and addressing.
	input wire		clk,
	input wire [3:0]	rd_addr,
	input wire [3:0]	wr_addr,
	// Datapath side.
	input wire		mem_wr_take,
	input wire [23:0]	mem_wr_data,
	output logic [23:0]	mem_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0]	words [16];
	logic		take_q = 1'b0;
	assign mem_rd_data = words[rd_addr];
	// The write word is only valid one edge after the take, so capture late.
	always @(posedge clk) begin
		take_q <= mem_wr_take;
		if (take_q) words[wr_addr] <= mem_wr_data;
	end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the subtractive adder datapath.
`include "sadd_map.vh"
`define CHK(n, e, a) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("Error %s expected %h seen %h", n, e, a); \
	end \
end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk = 1'b0;
	logic		reset_n = 1'b0;
	logic [5:0]	opcode;
	logic [1:0]	seq_kind;
	logic		x_clear, x_load, x_acc_msb, d_clear, d_load, mem_wr_take;
	logic		end_around, mem_wr_from_adder, load_refused;
	logic [2:0]	x_src;
	logic [3:0]	d_src, group_bypass, rd_addr, wr_addr;
	logic [23:0]	instr_word, jump_addr, acc, shift_data, pc, index_base, mem_rd_data;
	logic [23:0]	mem_wr_data, x_out, d_out, half_sub, half_level, full_sub, borrow_level;
	logic [23:0]	exp_x, exp_d, exp_w;
	logic [5:0]	d_ops [5] = '{6'h01, 6'h1B, 6'h1D, 6'h27, 6'h1E};
	logic [5:0]	x_ops [11] = '{6'h10, 6'h19, 6'h19, 6'h0A, 6'h0B, 6'h18, 6'h1E, 6'h06,
		6'h06, 6'h1C, 6'h1D};
	logic [1:0]	x_seq [11] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
	logic [2:0]	x_srcs [11] = '{3'h4, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5};
	int		mismatches = 0;
	int		num_checks = 0;
	int		i;

	always #2.5 clk = ~clk;

	sadd_mem_model u_mem (.clk, .rd_addr, .wr_addr, .mem_wr_take, .mem_wr_data, .mem_rd_data);
	sadd_datapath u_dut (.clk, .reset_n, .opcode, .seq_kind, .instr_word, .jump_addr, .x_clear,
		.x_load, .x_src, .x_acc_msb, .d_clear, .d_load, .d_src, .mem_rd_data, .mem_wr_take,
		.mem_wr_data, .mem_wr_from_adder, .acc, .shift_data, .pc, .index_base, .x_out, .d_out,
		.half_sub, .half_level, .full_sub, .borrow_level, .group_bypass, .end_around,
		.load_refused);

	function automatic [23:0] full_of(input [23:0] a, input [23:0] b);
		logic [24:0] s;
		s = a + b;
		if (s >= 25'h0FFFFFF) s = s - 25'h0FFFFFF;
		return s[23:0];
	endfunction

	// Per-stage borrow requests: odd stages report low, even stages high.
	function automatic [23:0] borrow_of(input [23:0] x, input [23:0] d);
		logic [23:0] h, nd, lv;
		logic b;
		nd = ~d;
		h = x ^ nd;
		b = 1'b0;
		// The second pass carries the wrapped borrow from the top stage.
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 24; k++) begin
				b = (h[k] & nd[k]) | (!h[k] & b);
				lv[k] = k[0] ? !b : b;
			end
		end
		return lv;
	endfunction

	// A group whose half bits are all equal cannot settle a borrow.
	function automatic [3:0] bypass_of(input [23:0] h);
		for (int g = 0; g < 4; g++) begin
			bypass_of[g] = (h[g*6 +: 6] == 6'h00) || (h[g*6 +: 6] == 6'h3F);
		end
	endfunction

	// Clear and load always travel together, so every load starts from zero.
	task automatic step(input [2:0] xs, input [3:0] ds, input logic xl, dl, wr);
		@(negedge clk);
		{x_clear, x_load, x_src, d_clear, d_load, d_src, mem_wr_take} = {xl, xl, xs, dl, dl, ds, wr};
		@(negedge clk);
		{x_clear, x_load, d_clear, d_load, mem_wr_take} = 5'h00;
	endtask

	task automatic chk_adder();
		`CHK("x_out", exp_x, x_out)
		`CHK("d_out", exp_d, d_out)
		`CHK("half_sub", exp_x ^ ~exp_d, half_sub)
		`CHK("full_sub", full_of(exp_x, exp_d), full_sub)
		`CHK("end_around", {1'b0, exp_x} + exp_d < 25'h0FFFFFF, end_around)
		`CHK("borrow_level", borrow_of(exp_x, exp_d), borrow_level)
		`CHK("group_bypass", bypass_of(exp_x ^ ~exp_d), group_bypass)
		`CHK("load_refused", 1'b0, load_refused)
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		{opcode, seq_kind, instr_word, jump_addr, acc, shift_data, pc, index_base} = '0;
		{x_clear, x_load, x_src, x_acc_msb, d_clear, d_load, d_src, mem_wr_take} = '0;
		{rd_addr, exp_x, exp_d} = '0;
		// Write-backs land in a word the scenarios never read from.
		wr_addr = 4'hF;
		void'($urandom(19755));
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		chk_adder();
		// The first two passes land exactly on the all-ones sum.
		for (i = 0; i < 24; i++) begin
			opcode = i[0] ? `SADD_OP_SUB : `SADD_OP_ADD;
			u_mem.words[0] = 24'($urandom);
			u_mem.words[1] = (i < 2) ? u_mem.words[0] ^ {24{~i[0]}} : 24'($urandom);
			rd_addr = 4'h0;
			step(`SADD_XS_MEM, 4'h0, 1'b1, 1'b0, 1'b0);
			exp_x = u_mem.words[0];
			rd_addr = 4'h1;
			step(3'h0, `SADD_DS_XFER, 1'b0, 1'b1, 1'b0);
			exp_d = i[0] ? ~exp_x : exp_x;
			step(`SADD_XS_MEM, 4'h0, 1'b1, 1'b0, 1'b0);
			exp_x = u_mem.words[1];
			chk_adder();
			step(3'h0, 4'h0, 1'b0, 1'b0, 1'b1);
			`CHK("mem_wr_data", full_of(exp_x, exp_d), mem_wr_data)
			`CHK("wr_from_adder", 1'b1, mem_wr_from_adder)
		end
		$display("arith test done");
		acc = 24'($urandom);
		instr_word = 24'($urandom);
		index_base = 24'($urandom);
		jump_addr = 24'($urandom);
		pc = 24'($urandom);
		shift_data = 24'($urandom);
		for (i = 0; i < 9; i++) begin
			opcode = (i > 4) ? `SADD_OP_ADD : d_ops[i];
			step(3'h0, 4'(i < 3 ? 2 : i), 1'b0, 1'b1, 1'b0);
			case (i)
				0, 1, 2: exp_d = ~acc;
				3: exp_d = {19'h00000, instr_word[18:14]};
				4: exp_d = index_base;
				5: exp_d = 24'h000001;
				6: exp_d = 24'h000002;
				7: exp_d = 24'hFFC000;
				default: exp_d = jump_addr;
			endcase
			chk_adder();
		end
		$display("operand test done");
		for (i = 0; i < 11; i++) begin
			opcode = x_ops[i];
			seq_kind = x_seq[i];
			x_acc_msb = (i == 9);
			step(x_srcs[i], 4'h0, 1'b1, 1'b0, 1'b0);
			case (x_srcs[i])
				3'h2: exp_x = pc;
				3'h3: exp_x = index_base;
				3'h5: exp_x = {shift_data[23:1], x_acc_msb ? acc[23] : shift_data[0]};
				default: exp_x = (i == 4) ? {10'h000, acc[13:0]} : acc;
			endcase
			chk_adder();
			step(3'h0, 4'h0, 1'b0, 1'b0, 1'b1);
			exp_w = (opcode inside {6'h0A, 6'h0B, 6'h10}) ? exp_x :
				(opcode inside {6'h1C, 6'h1D}) ? exp_x ^ ~exp_d : full_of(exp_x, exp_d);
			`CHK("mem_wr_data", exp_w, mem_wr_data)
			`CHK("wr_from_adder", !(opcode inside {6'h0A, 6'h0B, 6'h10}), mem_wr_from_adder)
			@(negedge clk);
			`CHK("mem_word", exp_w, u_mem.words[15])
		end
		$display("exchange test done");
		seq_kind = `SADD_SEQ_R;
		for (i = 0; i < 5; i++) begin
			opcode = i ? `SADD_OP_ADD : `SADD_OP_NEGATE;
			if (i < 2) begin
				step(i ? 3'h7 : `SADD_XS_ACC, 4'h0, 1'b1, 1'b0, 1'b0);
				exp_x = '0;
			end else begin
				step(3'h0, 4'(i == 4 ? 9 : 5 - i), 1'b0, 1'b1, 1'b0);
				exp_d = '0;
			end
			`CHK("load_refused", 1'b1, load_refused)
			@(negedge clk);
			chk_adder();
		end
		$display("refusal test done");
		wrap_up();
	end

	// About 300 cycles are needed; a margin well beyond that still ends quickly.
	initial begin
		#(5 * 4000);
		mismatches++;
		wrap_up();
	end
endmodule
